// ===== hdl/ctw_cond_eval.sv
// condition field evaluation against the condition code bits
`include "ctw_params.svh"
module ctw_cond_eval (
	input wire logic [3:0] cc_in,
	input wire logic [7:0] ccr_in,
	output logic true_out
);
	logic n_xor_v;
	logic unnorm;
	logic base;

	always_comb begin
		n_xor_v = ccr_in[`CTW_CCR_N] ^ ccr_in[`CTW_CCR_V];
		unnorm = ccr_in[`CTW_CCR_Z] |
			(~ccr_in[`CTW_CCR_U] & ~ccr_in[`CTW_CCR_E]);
		// low three bits pick the test, bit 3 inverts its sense
		case (cc_in[2:0])
			3'h0: base = ~ccr_in[`CTW_CCR_C];
			3'h1: base = ~n_xor_v;
			3'h2: base = ~ccr_in[`CTW_CCR_Z];
			3'h3: base = ~ccr_in[`CTW_CCR_N];
			3'h4: base = ~unnorm;
			3'h5: base = ~ccr_in[`CTW_CCR_E];
			3'h6: base = ~ccr_in[`CTW_CCR_L];
			3'h7: base = ~(ccr_in[`CTW_CCR_Z] | n_xor_v);
			default: base = 1'b0;
		endcase
		true_out = base ^ cc_in[3];
	end

endmodule // ctw_cond_eval

// ===== hdl/ctw_core.sv
// execution of software exception, test, split store and wait
//
// What this block does
// RL1 - software exception starts exception processing, level 3 on long routine
// RL2 - true conditional exception starts exception, level 3 on long routine
// RL3 - false conditional exception just continues with next instruction
// RL4 - accumulator test compares A or B with zero, sets flags, clears overflow
// RL5 - split store writes accumulator bits 47 to 24 to X at address
// RL6 - split store writes low 24 bits shifted left with fill bit to Y
// RL7 - wait gates core and memory clocks until an unmasked interrupt
// RL8 - oscillator and peripheral clocks keep running during wait
// RL9 - interrupt pending at wait is serviced at once, as if never waiting
// RL10 - unmasked interrupt or hardware reset ends wait and starts exception
// RL11 - debug request pin or JTAG debug command also ends wait
// RL12 - base count holds for internal fetch, no interlock, post or no update
// RL13 - pre-update addressing adds the pre-update penalty to the base
// RL14 - long absolute or long immediate adds its penalty; dash means none
// RL15 - bit set relative branch on peripheral operand takes 5 cycles
// RL16 - bit change on memory operand takes 2, plus 1 pre, plus 1 long
// RL17 - bit set on memory operand takes 2, plus 1 pre, plus 1 long
// RL18 - jump if bit clear on memory operand takes 4, plus 1 pre
// RL19 - exceptions, split store and wait leave condition codes untouched
`include "ctw_params.svh"
module ctw_core (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire ctw_pkg::ctw_instr_t instr_in,
	input wire ctw_pkg::ctw_acc_t acc_in,
	input wire logic [7:0] ccr_in,
	input wire logic long_isr_in,
	input wire logic irq_pend_in,
	input wire logic hw_reset_req_in,
	input wire logic debug_request_pin_in,
	input wire logic jtag_debug_cmd_in,
	output logic core_clk_en_out,
	output logic periph_clk_en_out,
	output ctw_pkg::ctw_exc_t exc_out,
	output logic ipl_wr_out,
	output logic [1:0] ipl_val_out,
	output ctw_pkg::ctw_ccr_wr_t ccr_wr_out,
	output ctw_pkg::ctw_mem_wr_t xmem_wr_out,
	output ctw_pkg::ctw_mem_wr_t ymem_wr_out,
	output logic instr_done_out,
	output logic [3:0] cycles_out
);
	import ctw_pkg::*;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	typedef enum logic {ST_RUN, ST_WAIT} ctw_state_t;

	ctw_state_t state_r, state_nxt;
	logic issue;
	logic is_trap, is_cond_soft_exception_instr, is_tst, is_vsl, is_wait;
	logic cond_true;
	logic wake;
	ctw_cause_t wake_cause;
	logic [55:0] tst_acc;
	logic [55:0] vsl_acc;
	logic [3:0] cost;

	// an instruction is only taken while the core is clocked
	assign issue = instr_in.valid && (state_r == ST_RUN);
	assign is_trap = issue && (instr_in.opcode == `CTW_OP_TRAP);
	assign is_wait = issue && (instr_in.opcode == `CTW_OP_WAIT);
	assign is_cond_soft_exception_instr = issue &&
		((instr_in.opcode & `CTW_COND_SOFT_EXCEPTION_INSTR_MASK) == `CTW_COND_SOFT_EXCEPTION_INSTR_VAL);
	assign is_tst = issue && !is_trap && !is_wait && !is_cond_soft_exception_instr &&
		((instr_in.opcode & `CTW_TST_MASK) == `CTW_TST_VAL);
	assign is_vsl = issue &&
		((instr_in.opcode & `CTW_VSL_MASK) == `CTW_VSL_VAL);
	assign tst_acc = instr_in.opcode[`CTW_TST_ACC_BIT] ?
		acc_in.b : acc_in.a;
	assign vsl_acc = instr_in.opcode[`CTW_VSL_ACC_BIT] ?
		acc_in.b : acc_in.a;

	ctw_cond_eval u_cond (
		.cc_in(instr_in.opcode[3:0]),
		.ccr_in(ccr_in),
		.true_out(cond_true)
	);

	ctw_cycle_cost u_cost (
		.tclass_in(instr_in.tclass),
		.amode_in(instr_in.amode),
		.cycles_out(cost)
	);

	// ----------------------------------------
	// wake sources, reset first
	// ----------------------------------------
	always_comb begin
		wake = 1'b1;
		if (hw_reset_req_in) begin
			wake_cause = EXC_HW_RESET; // RL10
		end else if (irq_pend_in) begin
			wake_cause = EXC_IRQ; // RL10
		end else if (debug_request_pin_in || jtag_debug_cmd_in) begin
			wake_cause = EXC_DEBUG; // RL11
		end else begin
			wake_cause = EXC_NONE;
			wake = 1'b0;
		end
	end

	// ----------------------------------------
	// state, exception and result registers
	// ----------------------------------------
	logic core_clk_en_r, core_clk_en_nxt;
	ctw_exc_t exc_r, exc_nxt;
	logic ipl_wr_r, ipl_wr_nxt;
	ctw_ccr_wr_t ccr_wr_r, ccr_wr_nxt;
	ctw_mem_wr_t xmem_r, xmem_nxt;
	ctw_mem_wr_t ymem_r, ymem_nxt;
	logic done_r, done_nxt;
	logic [3:0] cycles_r, cycles_nxt;
	logic periph_en_r;
	logic [1:0] ipl_val_r;

	always_comb begin
		state_nxt = state_r;
		core_clk_en_nxt = core_clk_en_r;
		exc_nxt = '{start: 1'b0, cause: EXC_NONE};
		ipl_wr_nxt = 1'b0;
		ccr_wr_nxt = '{en: 1'b0, ccr: ccr_in};
		xmem_nxt = '{en: 1'b0, addr: instr_in.ea,
			data: vsl_acc[47:24]};
		ymem_nxt = '{en: 1'b0, addr: instr_in.ea,
			data: {vsl_acc[22:0], instr_in.opcode[`CTW_VSL_FILL_BIT]}};
		done_nxt = issue;
		cycles_nxt = issue ? cost : cycles_r;
		case (state_r)
			ST_RUN: begin
				if (is_trap || (is_cond_soft_exception_instr && cond_true)) begin
					exc_nxt = '{start: 1'b1, cause: EXC_SOFT}; // RL1 RL2
					ipl_wr_nxt = long_isr_in; // RL1 RL2
				end
				// false condition: nothing beyond done_nxt, RL3
				if (is_tst) begin
					ccr_wr_nxt.en = 1'b1; // RL4
					ccr_wr_nxt.ccr[`CTW_CCR_N] = tst_acc[55];
					ccr_wr_nxt.ccr[`CTW_CCR_Z] = (tst_acc == 56'h0); // RL4
					ccr_wr_nxt.ccr[`CTW_CCR_V] = 1'b0; // RL4
					ccr_wr_nxt.ccr[`CTW_CCR_E] =
						!((&tst_acc[55:47]) || !(|tst_acc[55:47]));
					ccr_wr_nxt.ccr[`CTW_CCR_U] =
						!(tst_acc[47] ^ tst_acc[46]);
				end
				if (is_vsl) begin
					xmem_nxt.en = 1'b1; // RL5
					ymem_nxt.en = 1'b1; // RL6
				end
				if (is_wait) begin
					if (wake) begin
						// already pending: serviced, clocks stay on
						exc_nxt = '{start: wake_cause != EXC_DEBUG,
							cause: wake_cause}; // RL9
					end else begin
						state_nxt = ST_WAIT;
						core_clk_en_nxt = 1'b0; // RL7
					end
				end
			end
			ST_WAIT: begin
				if (wake) begin
					state_nxt = ST_RUN;
					core_clk_en_nxt = 1'b1; // RL10 RL11
					exc_nxt = '{start: wake_cause != EXC_DEBUG,
						cause: wake_cause}; // RL10
				end
			end
			default: begin
				state_nxt = ST_RUN;
				core_clk_en_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= ST_RUN;
			core_clk_en_r <= 1'b1;
			exc_r <= '{start: 1'b0, cause: EXC_NONE};
			ipl_wr_r <= 1'b0;
			ccr_wr_r <= '0;
			xmem_r <= '0;
			ymem_r <= '0;
			done_r <= 1'b0;
			cycles_r <= 4'h0;
			periph_en_r <= 1'b1;
			ipl_val_r <= `CTW_IPL_SWEXC;
		end else begin
			periph_en_r <= 1'b1; // RL8
			ipl_val_r <= `CTW_IPL_SWEXC; // RL1
			state_r <= state_nxt;
			core_clk_en_r <= core_clk_en_nxt;
			exc_r <= exc_nxt;
			ipl_wr_r <= ipl_wr_nxt;
			ccr_wr_r <= ccr_wr_nxt;
			xmem_r <= xmem_nxt;
			ymem_r <= ymem_nxt;
			done_r <= done_nxt;
			cycles_r <= cycles_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign core_clk_en_out = core_clk_en_r;
	assign periph_clk_en_out = periph_en_r; // RL8
	assign exc_out = exc_r;
	assign ipl_wr_out = ipl_wr_r;
	assign ipl_val_out = ipl_val_r; // RL1
	assign ccr_wr_out = ccr_wr_r;
	assign xmem_wr_out = xmem_r;
	assign ymem_wr_out = ymem_r;
	assign instr_done_out = done_r;
	assign cycles_out = cycles_r;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_soft_exc;
		exc_out.start && exc_out.cause == EXC_SOFT;
	endsequence

	sequence s_wait_entry;
		is_wait && !wake;
	endsequence

	sequence s_asleep;
		!core_clk_en_out && state_r == ST_WAIT;
	endsequence

	a_trap_exc_start: assert property ( // RL1
		is_trap |=> s_soft_exc and (ipl_wr_out == $past(long_isr_in)))
		else $error("trap did not start exception");

	a_cond_soft_exception_instr_taken: assert property ( // RL2
		is_cond_soft_exception_instr && cond_true && long_isr_in |=>
			s_soft_exc ##0 (ipl_wr_out && ipl_val_out == 2'h3))
		else $error("true conditional trap not taken");

	a_cond_soft_exception_instr_skip: assert property ( // RL3
		is_cond_soft_exception_instr && !cond_true |=> !exc_out.start && instr_done_out)
		else $error("false conditional trap took exception");

	a_tst_flags: assert property ( // RL4
		is_tst |=> ccr_wr_out.en && !ccr_wr_out.ccr[`CTW_CCR_V] &&
			ccr_wr_out.ccr[`CTW_CCR_Z] == ($past(tst_acc) == 56'h0) &&
			!xmem_wr_out.en && !ymem_wr_out.en)
		else $error("test flags wrong or result stored");

	a_vsl_x_word: assert property ( // RL5
		is_vsl |=> xmem_wr_out.en &&
			xmem_wr_out.data == $past(vsl_acc[47:24]) &&
			xmem_wr_out.addr == $past(instr_in.ea))
		else $error("split store X word wrong");

	a_vsl_y_word: assert property ( // RL6
		is_vsl |=> ymem_wr_out.en &&
			ymem_wr_out.addr == xmem_wr_out.addr &&
			ymem_wr_out.data[23:1] == $past(vsl_acc[22:0]) &&
			ymem_wr_out.data[0] ==
				$past(instr_in.opcode[`CTW_VSL_FILL_BIT]))
		else $error("split store Y word wrong");

	a_wait_gates: assert property ( // RL7
		s_wait_entry ##1 !wake [*3] |-> s_asleep)
		else $error("wait did not gate core clock");

	a_periph_alive: assert property ( // RL8
		s_asleep |-> periph_clk_en_out)
		else $error("peripheral clock stopped in wait");

	a_wait_pending: assert property ( // RL9
		is_wait && irq_pend_in && !hw_reset_req_in |=>
			core_clk_en_out && exc_out.start && exc_out.cause == EXC_IRQ)
		else $error("pending interrupt not serviced at wait");

	a_wait_wakeup: assert property ( // RL10
		s_asleep ##0 (irq_pend_in || hw_reset_req_in) |=>
			core_clk_en_out && exc_out.start)
		else $error("wait not left on interrupt or reset");

	a_debug_wake: assert property ( // RL11
		s_asleep ##0 (debug_request_pin_in || jtag_debug_cmd_in) |=>
			core_clk_en_out && state_r == ST_RUN)
		else $error("wait not left on debug request");

	a_base_count: assert property ( // RL12
		issue && instr_in.tclass == CL_TRAP |=> cycles_out == 4'h9)
		else $error("base count wrong");

	a_bit_set_rel_branch_instr_cost: assert property ( // RL15
		issue && instr_in.tclass == CL_BIT_SET_REL_BRANCH_PP |=>
			cycles_out == 4'h5)
		else $error("bit branch count not 5");

	a_bit_change_instr_cost: assert property ( // RL16
		issue && instr_in.tclass == CL_BIT_CHANGE_EA &&
			instr_in.amode == AM_PRE_UPDATE |=> cycles_out == 4'h3)
		else $error("bit change pre-update count not 3");

	a_bit_set_instr_cost: assert property ( // RL17
		issue && instr_in.tclass == CL_BIT_SET_EA &&
			instr_in.amode == AM_LONG_ABS |=> cycles_out == 4'h3)
		else $error("bit set long absolute count not 3");

	a_jump_if_bit_clear_instr_cost: assert property ( // RL18 RL14
		issue && instr_in.tclass == CL_JUMP_IF_BIT_CLEAR_EA |=>
			cycles_out == ($past(instr_in.amode) == AM_PRE_UPDATE ?
				4'h5 : 4'h4))
		else $error("jump if bit clear count wrong");

	a_ccr_kept: assert property ( // RL19
		(is_trap || is_cond_soft_exception_instr || is_vsl || is_wait) |=> !ccr_wr_out.en)
		else $error("condition codes written");

endmodule // ctw_core

// ===== hdl/ctw_cycle_cost.sv
// clock cycle count of an instruction from its form and addressing
`include "ctw_params.svh"
module ctw_cycle_cost
	import ctw_pkg::*;
(
	input wire ctw_pkg::ctw_tclass_t tclass_in,
	input wire ctw_pkg::ctw_amode_t amode_in,
	output logic [3:0] cycles_out
);

	// base count plus the penalty of the addressing in use
	function automatic logic [3:0] cost(input logic [3:0] t,
		input logic [3:0] pru, input logic [3:0] lab,
		input logic [3:0] lim, input ctw_amode_t am);
		logic [3:0] add;
		case (am)
			AM_PRE_UPDATE: add = pru; // RL13
			AM_LONG_ABS: add = lab; // RL14
			AM_LONG_IMM: add = lim; // RL14
			default: add = `CTW_NONE; // RL12
		endcase
		return t + add;
	endfunction

	always_comb begin
		case (tclass_in)
			CL_TRAP: cycles_out = cost(`CTW_T_TRAP, `CTW_NONE,
				`CTW_NONE, `CTW_NONE, amode_in);
			CL_WAIT: cycles_out = cost(`CTW_T_WAIT, `CTW_NONE,
				`CTW_NONE, `CTW_NONE, amode_in);
			CL_VSL: cycles_out = cost(`CTW_T_VSL, `CTW_PRU_VSL,
				`CTW_LAB_VSL, `CTW_NONE, amode_in);
			CL_BIT_SET_REL_BRANCH_PP: cycles_out = cost(
				`CTW_T_BIT_SET_REL_BRANCH_INSTR_PP, `CTW_NONE, `CTW_NONE,
				`CTW_NONE, amode_in); // RL15
			CL_BIT_CHANGE_EA: cycles_out = cost(`CTW_T_BIT_CHANGE_INSTR_EA,
				`CTW_PRU_BIT_CHANGE_INSTR_EA, `CTW_LAB_BIT_CHANGE_INSTR_EA,
				`CTW_NONE, amode_in); // RL16
			CL_BIT_SET_EA: cycles_out = cost(`CTW_T_BIT_SET_INSTR_EA,
				`CTW_PRU_BIT_SET_INSTR_EA, `CTW_LAB_BIT_SET_INSTR_EA,
				`CTW_NONE, amode_in); // RL17
			CL_JUMP_IF_BIT_CLEAR_EA: cycles_out = cost(
				`CTW_T_JUMP_IF_BIT_CLEAR_INSTR_EA, `CTW_PRU_JUMP_IF_BIT_CLEAR_INSTR_EA, `CTW_NONE,
				`CTW_NONE, amode_in); // RL18
			default: cycles_out = `CTW_T_DEFAULT;
		endcase
	end

endmodule // ctw_cycle_cost

// ===== hdl/ctw_params.svh
// constants for the trap, wait, test and timing block
`ifndef CTW_PARAMS_SVH
`define CTW_PARAMS_SVH

// ----------------------------------------
// opcode patterns
// ----------------------------------------
`define CTW_OP_TRAP 24'h000006
`define CTW_OP_WAIT 24'h000086
`define CTW_COND_SOFT_EXCEPTION_INSTR_MASK 24'hFFFFF0
`define CTW_COND_SOFT_EXCEPTION_INSTR_VAL 24'h000010
`define CTW_TST_MASK 24'h0000F7
`define CTW_TST_VAL 24'h000003
`define CTW_TST_ACC_BIT 3
`define CTW_VSL_MASK 24'hFEC0EF
`define CTW_VSL_VAL 24'h0AC0C0
`define CTW_VSL_ACC_BIT 16
`define CTW_VSL_FILL_BIT 4

// ----------------------------------------
// condition code bit positions
// ----------------------------------------
`define CTW_CCR_C 0
`define CTW_CCR_V 1
`define CTW_CCR_Z 2
`define CTW_CCR_N 3
`define CTW_CCR_U 4
`define CTW_CCR_E 5
`define CTW_CCR_L 6
`define CTW_CCR_S 7

// ----------------------------------------
// status register values
// ----------------------------------------
`define CTW_IPL_SWEXC 2'h3

// ----------------------------------------
// clock cycle costs, zero where not applicable
// ----------------------------------------
`define CTW_T_DEFAULT 4'h1
`define CTW_T_TRAP 4'h9
`define CTW_T_WAIT 4'hA
`define CTW_T_VSL 4'h1
`define CTW_PRU_VSL 4'h1
`define CTW_LAB_VSL 4'h1
`define CTW_T_BIT_SET_REL_BRANCH_INSTR_PP 4'h5
`define CTW_T_BIT_CHANGE_INSTR_EA 4'h2
`define CTW_PRU_BIT_CHANGE_INSTR_EA 4'h1
`define CTW_LAB_BIT_CHANGE_INSTR_EA 4'h1
`define CTW_T_BIT_SET_INSTR_EA 4'h2
`define CTW_PRU_BIT_SET_INSTR_EA 4'h1
`define CTW_LAB_BIT_SET_INSTR_EA 4'h1
`define CTW_T_JUMP_IF_BIT_CLEAR_INSTR_EA 4'h4
`define CTW_PRU_JUMP_IF_BIT_CLEAR_INSTR_EA 4'h1
`define CTW_NONE 4'h0

`endif

// ===== hdl/ctw_pkg.sv
// types shared by the trap, wait, test and timing block
package ctw_pkg;

	// ----------------------------------------
	// enumerations
	// ----------------------------------------
	typedef enum logic [2:0] {
		CL_OTHER, CL_TRAP, CL_WAIT, CL_VSL,
		CL_BIT_SET_REL_BRANCH_PP, CL_BIT_CHANGE_EA,
		CL_BIT_SET_EA, CL_JUMP_IF_BIT_CLEAR_EA
	} ctw_tclass_t;

	typedef enum logic [2:0] {
		AM_NO_UPDATE, AM_POST_UPDATE, AM_PRE_UPDATE,
		AM_LONG_ABS, AM_LONG_IMM
	} ctw_amode_t;

	typedef enum logic [2:0] {
		EXC_NONE, EXC_SOFT, EXC_IRQ, EXC_HW_RESET, EXC_DEBUG
	} ctw_cause_t;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic [23:0] opcode;
		ctw_tclass_t tclass;
		ctw_amode_t amode;
		logic [23:0] ea;
	} ctw_instr_t;

	typedef struct packed {
		logic [55:0] a;
		logic [55:0] b;
	} ctw_acc_t;

	typedef struct packed {
		logic start;
		ctw_cause_t cause;
	} ctw_exc_t;

	typedef struct packed {
		logic en;
		logic [7:0] ccr;
	} ctw_ccr_wr_t;

	typedef struct packed {
		logic en;
		logic [23:0] addr;
		logic [23:0] data;
	} ctw_mem_wr_t;

endpackage

// ===== testbench/test_ctw_core.sv
// self-checking bench for the trap, wait, test and timing block
`include "ctw_params.svh"
module test_ctw_core;
	timeunit 1ns;
	timeprecision 100ps;
	import ctw_pkg::*;

	// ----------------------------------------
	// signals and design
	// ----------------------------------------
	localparam logic [3:0] WK [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hC, 4'hA};
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	ctw_instr_t instr_in;
	ctw_acc_t acc_in;
	logic [7:0] ccr_in;
	logic long_isr_in, irq_pend_in, hw_reset_req_in;
	logic debug_request_pin_in, jtag_debug_cmd_in;
	logic core_clk_en_out, periph_clk_en_out, ipl_wr_out, instr_done_out;
	ctw_exc_t exc_out;
	logic [1:0] ipl_val_out;
	ctw_ccr_wr_t ccr_wr_out;
	ctw_mem_wr_t xmem_wr_out, ymem_wr_out;
	logic [3:0] cycles_out;
	int n_mismatch = 0;
	int tests_run = 0;

	ctw_core dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.instr_in(instr_in), .acc_in(acc_in), .ccr_in(ccr_in),
		.long_isr_in(long_isr_in), .irq_pend_in(irq_pend_in),
		.hw_reset_req_in(hw_reset_req_in),
		.debug_request_pin_in(debug_request_pin_in),
		.jtag_debug_cmd_in(jtag_debug_cmd_in),
		.core_clk_en_out(core_clk_en_out),
		.periph_clk_en_out(periph_clk_en_out), .exc_out(exc_out),
		.ipl_wr_out(ipl_wr_out), .ipl_val_out(ipl_val_out),
		.ccr_wr_out(ccr_wr_out), .xmem_wr_out(xmem_wr_out),
		.ymem_wr_out(ymem_wr_out), .instr_done_out(instr_done_out),
		.cycles_out(cycles_out));

	always #2 clk_in = ~clk_in;

	// ----------------------------------------
	// compare and report
	// ----------------------------------------
	task automatic chkf(input string nm, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic chkv(input string nm, input logic [55:0] e,
		input logic [55:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----------------------------------------
	// reference model
	// ----------------------------------------
	function automatic logic [3:0] cost(input ctw_tclass_t t,
		input ctw_amode_t m);
		int pre, lab;
		pre = (m == AM_PRE_UPDATE);
		lab = (m == AM_LONG_ABS);
		case (t)
			CL_TRAP: cost = 4'h9;
			CL_WAIT: cost = 4'hA;
			CL_VSL: cost = 4'(1 + pre + lab);
			CL_BIT_SET_REL_BRANCH_PP: cost = 4'h5;
			CL_BIT_CHANGE_EA: cost = 4'(2 + pre + lab);
			CL_BIT_SET_EA: cost = 4'(2 + pre + lab);
			CL_JUMP_IF_BIT_CLEAR_EA: cost = 4'(4 + pre);
			default: cost = 4'h1;
		endcase
	endfunction

	function automatic logic cond_true(input logic [3:0] c,
		input logic [7:0] r);
		logic t;
		case (c[2:0])
			3'h0: t = !r[0];
			3'h1: t = !(r[3] ^ r[1]);
			3'h2: t = !r[2];
			3'h3: t = !r[3];
			3'h4: t = !(r[2] | (!r[4] & !r[5]));
			3'h5: t = !r[5];
			3'h6: t = !r[6];
			default: t = !(r[2] | (r[3] ^ r[1]));
		endcase
		return c[3] ? !t : t;
	endfunction

	function automatic logic [55:0] racc();
		logic [55:0] v;
		v = 56'({$urandom, $urandom});
		case ($urandom % 4)
			0: v = '0;
			1: v = {{8{v[47]}}, v[47:0]};
			default: ;
		endcase
		return v;
	endfunction

	// ----------------------------------------
	// stimulus tasks
	// ----------------------------------------
	// wk holds irq, hardware reset, debug pin, jtag command
	task automatic drive(input logic [23:0] op, input ctw_tclass_t tc,
		input ctw_amode_t am, input logic [3:0] wk);
		instr_in = '{1'b1, op, tc, am, 24'($urandom)};
		acc_in = '{racc(), racc()};
		ccr_in = 8'($urandom);
		long_isr_in = 1'($urandom);
		irq_pend_in = wk[3];
		hw_reset_req_in = wk[2];
		debug_request_pin_in = wk[1];
		jtag_debug_cmd_in = wk[0];
	endtask

	task automatic exec(input logic [23:0] op, input ctw_tclass_t tc,
		input ctw_amode_t am);
		logic [55:0] acc;
		logic [7:0] c, ec;
		logic trp, tst, viterbi_split_store_instr;
		drive(op, tc, am, 4'($urandom));
		c = ccr_in;
		trp = op == `CTW_OP_TRAP || ((op & `CTW_COND_SOFT_EXCEPTION_INSTR_MASK) ==
			`CTW_COND_SOFT_EXCEPTION_INSTR_VAL && cond_true(op[3:0], c));
		tst = (op & `CTW_TST_MASK) == `CTW_TST_VAL;
		viterbi_split_store_instr = (op & `CTW_VSL_MASK) == `CTW_VSL_VAL;
		acc = op[viterbi_split_store_instr ? 16 : 3] ? acc_in.b : acc_in.a;
		ec = {c[7:6], !(&acc[55:47] || ~|acc[55:47]),
			~(acc[47] ^ acc[46]), acc[55], ~|acc, 1'b0, c[0]};
		@(posedge clk_in);
		#1;
		chkf("done", 1'b1, instr_done_out);
		chkv("cycles", cost(tc, am), cycles_out);
		chkf("core clk", 1'b1, core_clk_en_out);
		chkf("exc start", trp, exc_out.start);
		if (trp) chkv("exc cause", EXC_SOFT, exc_out.cause);
		chkf("ipl write", trp & long_isr_in, ipl_wr_out);
		chkv("ipl value", 2'h3, ipl_val_out);
		chkf("ccr write", tst, ccr_wr_out.en);
		if (tst) chkv("ccr", ec, ccr_wr_out.ccr);
		chkf("x write", viterbi_split_store_instr, xmem_wr_out.en);
		chkf("y write", viterbi_split_store_instr, ymem_wr_out.en);
		if (viterbi_split_store_instr) begin
			chkv("x addr", instr_in.ea, xmem_wr_out.addr);
			chkv("x data", acc[47:24], xmem_wr_out.data);
			chkv("y addr", instr_in.ea, ymem_wr_out.addr);
			chkv("y data", {acc[22:0], op[4]}, ymem_wr_out.data);
		end
	endtask

	task automatic wait_run(input logic [3:0] wk, input int dly);
		ctw_cause_t ce;
		ce = wk[2] ? EXC_HW_RESET : (wk[3] ? EXC_IRQ : EXC_DEBUG);
		drive(`CTW_OP_WAIT, CL_WAIT, AM_NO_UPDATE, dly == 0 ? wk : 4'h0);
		@(posedge clk_in);
		#1;
		chkf("done", 1'b1, instr_done_out);
		chkv("cycles", 4'hA, cycles_out);
		chkf("ccr write", 1'b0, ccr_wr_out.en);
		for (int i = 1; i <= dly; i++) begin
			chkf("core clk off", 1'b0, core_clk_en_out);
			chkf("periph clk", 1'b1, periph_clk_en_out);
			chkf("exc start", 1'b0, exc_out.start);
			drive(`CTW_OP_TRAP, CL_TRAP, AM_NO_UPDATE, i == dly ? wk : 4'h0);
			@(posedge clk_in);
			#1;
			chkf("done in wait", 1'b0, instr_done_out);
		end
		chkf("core clk on", 1'b1, core_clk_en_out);
		chkf("exc start", ce != EXC_DEBUG, exc_out.start);
		chkv("exc cause", ce, exc_out.cause);
	endtask

	task automatic chk_reset();
		chkf("reset clk", 1'b1, core_clk_en_out);
		chkf("reset periph", 1'b1, periph_clk_en_out);
		chkv("reset cycles", 4'h0, cycles_out);
		chkf("reset done", 1'b0, instr_done_out);
		chkf("reset exc", 1'b0, exc_out.start);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		#20000;
		n_mismatch++;
		results();
	end

	initial begin
		instr_in = '0;
		acc_in = '0;
		ccr_in = '0;
		long_isr_in = 1'b0;
		irq_pend_in = 1'b0;
		hw_reset_req_in = 1'b0;
		debug_request_pin_in = 1'b0;
		jtag_debug_cmd_in = 1'b0;
		void'($urandom(30999));
		repeat (5) @(posedge clk_in);
		#1;
		chk_reset();
		rst_n_in = 1'b1;
		for (int i = 0; i < 8; i++) begin
			exec(`CTW_OP_TRAP, CL_TRAP, ctw_amode_t'(i % 5));
		end
		for (int i = 0; i < 64; i++) begin
			exec(`CTW_COND_SOFT_EXCEPTION_INSTR_VAL | 24'(i % 16), CL_TRAP, AM_NO_UPDATE);
		end
		for (int i = 0; i < 24; i++) begin
			exec({16'($urandom), 4'h0, i[0], 3'h3}, CL_OTHER, AM_POST_UPDATE);
		end
		for (int i = 0; i < 20; i++) begin
			exec(`CTW_VSL_VAL | (24'($urandom) & ~`CTW_VSL_MASK), CL_VSL,
				ctw_amode_t'(i % 5));
		end
		for (int t = 0; t < 8; t++) begin
			for (int m = 0; m < 5; m++) begin
				exec(24'h000000, ctw_tclass_t'(t), ctw_amode_t'(m));
			end
		end
		for (int k = 0; k < 6; k++) begin
			for (int d = 0; d < 3; d++) begin
				wait_run(WK[k], d * 2);
			end
		end
		drive(`CTW_OP_WAIT, CL_WAIT, AM_NO_UPDATE, 4'h0);
		repeat (2) @(posedge clk_in);
		#1;
		rst_n_in = 1'b0;
		#1;
		chk_reset();
		repeat (2) @(posedge clk_in);
		#1;
		rst_n_in = 1'b1;
		exec(`CTW_OP_TRAP, CL_TRAP, AM_NO_UPDATE);
		results();
	end
endmodule // test_ctw_core
